// *** rtl/adc_ctrl_pkg.sv ***
// Constants, types and states shared by the converter control block.
// Function
// - One output pin flags ready and shifts data
// - External clock stops oscillator and drives timing
// - System clock divided down for modulator sampling
// - Either supply event restores default conditions
// - Digital power-on triggers startup self-calibration
// - Fourth-order sinc filter decimates modulator bitstream
// - Single-cycle clears filter, continuous keeps it
// - Filter corner sits at 24% of rate
// - Output rate set by speed grade and system clock
// - Two wires: host clock in, data out
// - Output idles high, low when result ready
// - Sixteen bits MSB first, 25th pulse idles high
// - 26th pulse falling edge starts self-calibration
// - Clock held high sleeps, low wakes
package adc_ctrl_pkg;
    localparam longint CLK_HZ         = 40000000;
    localparam longint OSC_A_HZ       = 2457600;
    localparam longint OSC_B_HZ       = 2252800;
    localparam int     NCO_BITS       = 24;
    localparam int     SAMPLE_DIV     = 10;
    localparam int     DEC_LOG2_A     = 11;
    localparam int     DEC_LOG2_B     = 14;
    localparam int     SINC_ORDER     = 4;
    localparam int     ACC_W          = SINC_ORDER * DEC_LOG2_B + 2;
    localparam int     RES_W          = 16;
    localparam int     SETTLE_OUTPUTS = 3;
    localparam int     EXT_TIMEOUT    = 64;
    localparam longint CAL_TIME_A_US  = 199700;
    localparam longint CAL_TIME_B_US  = 183100;
    localparam longint CAL_CYCLES_A   = CAL_TIME_A_US * CLK_HZ / 1000000;
    localparam longint CAL_CYCLES_B   = CAL_TIME_B_US * CLK_HZ / 1000000;
    localparam longint SLEEP_HOLD_US  = 100;
    localparam int     SLEEP_CYCLES   = int'(SLEEP_HOLD_US * CLK_HZ / 1000000);
    localparam logic [4:0] PULSE_LAST_BIT = 5'h10;
    localparam logic [4:0] PULSE_IDLE     = 5'h19;
    localparam logic [4:0] PULSE_CAL      = 5'h1A;
    localparam logic [RES_W-1:0] CODE_MAX = 16'h7FFF;
    localparam logic [RES_W-1:0] CODE_MIN = 16'h8000;

    typedef struct packed {
        logic             after_cal;
        logic [RES_W-1:0] code;
    } result_t;

    typedef enum logic [1:0] {
        ST_CAL,
        ST_CONV,
        ST_READ,
        ST_SLEEP
    } ctrl_state_t;
endpackage

// *** rtl/adc_conversion_and_readout_ctrl.sv ***
// Conversion sequencing, sinc decimation and two-wire readout of the converter.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_and_readout_ctrl #(
    parameter bit     GRADE_B    = 1'b0,
    parameter longint CAL_CYCLES = GRADE_B ? adc_ctrl_pkg::CAL_CYCLES_B
                                           : adc_ctrl_pkg::CAL_CYCLES_A,
    parameter int     DEC_LOG2   = GRADE_B ? adc_ctrl_pkg::DEC_LOG2_B : adc_ctrl_pkg::DEC_LOG2_A
) (
    input  wire logic clock_i,
    input  wire logic reset_i,
    input  wire logic digital_supply_ok_i,
    input  wire logic analog_supply_ok_i,
    input  wire logic ext_clock_i,
    input  wire logic modulator_bit_i,
    input  wire logic sclk_i,
    output logic      dout_o,
    output logic      osc_enable_o,
    output logic      sample_tick_o,
    output logic      cal_active_o,
    output logic      sleep_o
);
    import adc_ctrl_pkg::*;

    localparam longint OSC_HZ   = GRADE_B ? OSC_B_HZ : OSC_A_HZ;
    localparam logic [NCO_BITS-1:0] OSC_INC = NCO_BITS'((OSC_HZ * (64'h1 << NCO_BITS)) / CLK_HZ);
    localparam int OUT_TOP  = SINC_ORDER * DEC_LOG2;

    logic                  por_hold;
    ctrl_state_t           state_r;
    logic                  sclk_q_r;
    logic                  ext_q_r;
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  ext_rise;
    logic [NCO_BITS-1:0]   nco_r;
    logic [NCO_BITS:0]     nco_sum;
    logic [6:0]            ext_idle_r;
    logic                  ext_active_r;
    logic                  sys_tick;
    logic [3:0]            samp_div_r;
    logic                  samp_tick;
    logic                  filt_run;
    logic                  filt_clear;
    logic signed [ACC_W-1:0] integ_r [SINC_ORDER];
    logic signed [ACC_W-1:0] dly_r   [SINC_ORDER];
    logic signed [ACC_W-1:0] integ_in [SINC_ORDER];
    logic signed [ACC_W-1:0] comb_v  [SINC_ORDER+1];
    logic [DEC_LOG2_B-1:0] dec_cnt_r;
    logic                  dec_tick;
    logic [1:0]            settle_r;
    logic [RES_W-1:0]      code_v;
    result_t               pend_r;
    logic                  pend_valid_r;
    logic                  after_cal_r;
    result_t               buf_r [2];
    logic                  buf_wp_r;
    logic                  buf_rp_r;
    logic [1:0]            buf_cnt_r;
    logic                  buf_in_ready;
    logic                  buf_out_valid;
    logic                  buf_push;
    logic [RES_W-1:0]      shift_r;
    logic [4:0]            pulses_r;
    logic                  dout_r;
    logic                  wake_cal_r;
    logic [31:0]           cal_cnt_r;
    logic [12:0]           high_cnt_r;
    logic                  load_ok;

    // Either supply dropping holds the whole block in its defaults.
    assign por_hold  = reset_i | ~digital_supply_ok_i | ~analog_supply_ok_i;
    assign sclk_rise = sclk_i & ~sclk_q_r;
    assign sclk_fall = ~sclk_i & sclk_q_r;
    assign ext_rise  = ext_clock_i & ~ext_q_r;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sclk_q_r <= 1'b0;
            ext_q_r  <= 1'b0;
        end else begin
            sclk_q_r <= sclk_i;
            ext_q_r  <= ext_clock_i;
        end
    end

    // Internal oscillator model: a phase accumulator at the trimmed rate.
    assign nco_sum = {1'b0, nco_r} + {1'b0, OSC_INC};

    always_ff @(posedge clock_i) begin
        if (por_hold || ext_active_r) begin
            nco_r <= '0;
        end else begin
            nco_r <= nco_sum[NCO_BITS-1:0];
        end
    end

    // Edges on the external clock pin keep the oscillator switched off; a quiet
    // pin for a short while hands timing back to the internal source.
    always_ff @(posedge clock_i) begin
        if (por_hold) begin
            ext_idle_r   <= '0;
            ext_active_r <= 1'b0;
        end else if (ext_rise) begin
            ext_idle_r   <= '0;
            ext_active_r <= 1'b1;
        end else if (ext_idle_r == 7'(EXT_TIMEOUT)) begin
            ext_active_r <= 1'b0;
        end else begin
            ext_idle_r <= ext_idle_r + 7'h01;
        end
    end

    assign sys_tick = ext_active_r ? ext_rise : nco_sum[NCO_BITS];

    // The modulator sample rate is the system clock divided down.
    always_ff @(posedge clock_i) begin
        if (por_hold || state_r == ST_SLEEP) begin
            samp_div_r <= '0;
        end else if (sys_tick) begin
            samp_div_r <= (samp_div_r == 4'(SAMPLE_DIV - 1)) ? 4'h0 : samp_div_r + 4'h1;
        end
    end

    assign samp_tick = sys_tick && samp_div_r == 4'(SAMPLE_DIV - 1);
    assign filt_run  = samp_tick && state_r != ST_SLEEP && state_r != ST_CAL;
    assign dec_tick  = filt_run && dec_cnt_r == DEC_LOG2_B'((1 << DEC_LOG2) - 1);

    // Sinc-4 decimator: cascaded integrators at the sample rate, combs at the
    // output rate. A fourth-order sinc puts its corner near a quarter of the rate.
    generate
        for (genvar i = 0; i < SINC_ORDER; i++) begin : g_sinc
            if (i > 0) begin : g_chain
                assign integ_in[i] = integ_r[i-1];
            end
            always_ff @(posedge clock_i) begin
                if (por_hold || filt_clear) begin
                    integ_r[i] <= '0;
                    dly_r[i]   <= '0;
                end else begin
                    if (filt_run) begin
                        integ_r[i] <= integ_r[i] + integ_in[i];
                    end
                    if (dec_tick) begin
                        dly_r[i] <= comb_v[i];
                    end
                end
            end
            assign comb_v[i+1] = comb_v[i] - dly_r[i];
        end
    endgenerate

    assign comb_v[0] = integ_r[SINC_ORDER-1];
    assign integ_in[0] = modulator_bit_i ? ACC_W'(1) : -ACC_W'(1);

    // Full positive scale would wrap into the sign bit, so clamp both ends.
    always_comb begin
        if (comb_v[SINC_ORDER] >= (ACC_W'(1) <<< OUT_TOP)) begin
            code_v = CODE_MAX;
        end else if (comb_v[SINC_ORDER] < -(ACC_W'(1) <<< OUT_TOP)) begin
            code_v = CODE_MIN;
        end else begin
            code_v = comb_v[SINC_ORDER][OUT_TOP -: RES_W];
        end
    end

    always_ff @(posedge clock_i) begin
        if (por_hold || filt_clear) begin
            dec_cnt_r <= '0;
        end else if (filt_run) begin
            dec_cnt_r <= dec_tick ? '0 : dec_cnt_r + DEC_LOG2_B'(1);
        end
    end

    // After a filter clear the first outputs are still settling and are dropped.
    always_ff @(posedge clock_i) begin
        if (por_hold || filt_clear) begin
            settle_r <= 2'(SETTLE_OUTPUTS);
        end else if (dec_tick && settle_r != 2'h0) begin
            settle_r <= settle_r - 2'h1;
        end
    end

    // A result waits here while the buffer is full; a newer one overwrites it,
    // which is how unread old data is lost. Words older than a calibration or a
    // wake-up are stale and are dropped together with the filter state.
    always_ff @(posedge clock_i) begin
        if (por_hold || filt_clear) begin
            pend_r       <= '0;
            pend_valid_r <= 1'b0;
        end else if (dec_tick && settle_r == 2'h0) begin
            pend_r       <= '{after_cal: after_cal_r, code: code_v};
            pend_valid_r <= 1'b1;
        end else if (buf_push) begin
            pend_valid_r <= 1'b0;
        end
    end

    assign buf_in_ready  = buf_cnt_r != 2'h2;
    assign buf_out_valid = buf_cnt_r != 2'h0;
    assign buf_push      = pend_valid_r && buf_in_ready && !(dec_tick && settle_r == 2'h0);

    always_ff @(posedge clock_i) begin
        if (por_hold || filt_clear) begin
            buf_wp_r  <= 1'b0;
            buf_rp_r  <= 1'b0;
            buf_cnt_r <= '0;
            buf_r[0]  <= '0;
            buf_r[1]  <= '0;
        end else begin
            if (buf_push) begin
                buf_r[buf_wp_r] <= pend_r;
                buf_wp_r        <= ~buf_wp_r;
            end
            if (load_ok) begin
                buf_rp_r <= ~buf_rp_r;
            end
            buf_cnt_r <= buf_cnt_r + {1'b0, buf_push} - {1'b0, load_ok};
        end
    end

    // A new word is only presented while the clock is low, so ready always falls
    // in a clock-low phase and never in the middle of a shift.
    assign load_ok = buf_out_valid && !sclk_i && (state_r == ST_CONV ||
                     (state_r == ST_READ && pulses_r >= PULSE_LAST_BIT &&
                      pulses_r < PULSE_CAL));

    always_ff @(posedge clock_i) begin
        if (por_hold) begin
            shift_r  <= '0;
            pulses_r <= '0;
            dout_r   <= 1'b1;
        end else if (state_r == ST_SLEEP || state_r == ST_CAL) begin
            pulses_r <= '0;
            dout_r   <= 1'b1;
        end else if (load_ok) begin
            shift_r  <= buf_r[buf_rp_r].code;
            pulses_r <= '0;
            dout_r   <= 1'b0;
        end else if (state_r == ST_READ && sclk_rise && pulses_r != PULSE_CAL) begin
            pulses_r <= pulses_r + 5'h01;
            if (pulses_r < PULSE_LAST_BIT) begin
                dout_r  <= shift_r[RES_W-1];
                shift_r <= {shift_r[RES_W-2:0], 1'b0};
            end else if (pulses_r == PULSE_IDLE - 5'h01) begin
                dout_r <= 1'b1;
            end
        end
    end

    assign dout_o = dout_r;

    always_ff @(posedge clock_i) begin
        if (por_hold || !sclk_i || state_r != ST_READ) begin
            high_cnt_r <= '0;
        end else if (high_cnt_r != 13'(SLEEP_CYCLES)) begin
            high_cnt_r <= high_cnt_r + 13'h0001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (por_hold || state_r != ST_CAL) begin
            cal_cnt_r <= '0;
        end else begin
            cal_cnt_r <= cal_cnt_r + 32'h0000_0001;
        end
    end

    // Loss of the digital supply restarts with calibration; an analog-only
    // event restarts plain conversion from defaults.
    always_ff @(posedge clock_i) begin
        if (reset_i || !digital_supply_ok_i) begin
            state_r    <= ST_CAL;
            wake_cal_r <= 1'b0;
        end else if (!analog_supply_ok_i) begin
            state_r    <= ST_CONV;
            wake_cal_r <= 1'b0;
        end else begin
            case (state_r)
                ST_CAL: begin
                    if (cal_cnt_r >= 32'(CAL_CYCLES - 1)) begin
                        state_r <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (load_ok) begin
                        state_r <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (high_cnt_r == 13'(SLEEP_CYCLES)) begin
                        state_r    <= ST_SLEEP;
                        wake_cal_r <= pulses_r == PULSE_CAL;
                    end else if (sclk_fall && pulses_r == PULSE_CAL) begin
                        state_r <= ST_CAL;
                    end
                end
                ST_SLEEP: begin
                    if (!sclk_i) begin
                        state_r    <= wake_cal_r ? ST_CAL : ST_CONV;
                        wake_cal_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_CAL;
                end
            endcase
        end
    end

    // Filter is cleared entering calibration or waking from sleep: single-cycle
    // operation. Continuous operation never passes here and keeps its state.
    assign filt_clear = (state_r == ST_CAL) ||
                        (state_r == ST_SLEEP && !sclk_i);

    always_ff @(posedge clock_i) begin
        if (por_hold) begin
            after_cal_r <= 1'b1;
        end else if (state_r == ST_CAL) begin
            after_cal_r <= 1'b1;
        end else if (dec_tick && settle_r == 2'h0) begin
            after_cal_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (por_hold) begin
            osc_enable_o  <= 1'b1;
            cal_active_o  <= 1'b0;
            sleep_o       <= 1'b0;
            sample_tick_o <= 1'b0;
        end else begin
            osc_enable_o  <= ~ext_active_r;
            cal_active_o  <= state_r == ST_CAL;
            sleep_o       <= state_r == ST_SLEEP;
            sample_tick_o <= samp_tick && state_r != ST_SLEEP;
        end
    end
endmodule
`default_nettype wire

// *** bench/adc_ctrl_asserts.sv ***
// Port-level checks of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_asserts (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic digital_supply_ok_i,
    input wire logic analog_supply_ok_i,
    input wire logic ext_clock_i,
    input wire logic sclk_i,
    input wire logic dout_o,
    input wire logic osc_enable_o,
    input wire logic sample_tick_o,
    input wire logic cal_active_o,
    input wire logic sleep_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // Reset itself is the antecedent here, so this one must not be disabled by it.
    reset_idle_a: assert property (disable iff (1'b0)
        reset_i |=> dout_o && osc_enable_o && !cal_active_o && !sleep_o && !sample_tick_o)
        else $error("defaults not held during reset");
    cal_start_a: assert property (
        ($fell(reset_i) || $rose(digital_supply_ok_i)) && digital_supply_ok_i
        && analog_supply_ok_i |-> ##[0:3] cal_active_o)
        else $error("no calibration after digital power-on");
    supply_low_a: assert property (
        !digital_supply_ok_i || !analog_supply_ok_i |=> dout_o && !cal_active_o && !sleep_o)
        else $error("supply event did not restore defaults");
    cal_quiet_a: assert property (cal_active_o |-> dout_o)
        else $error("ready shown during calibration");
    sleep_quiet_a: assert property (sleep_o |-> dout_o && !sample_tick_o)
        else $error("output low or sampling in sleep");
    sleep_hold_a: assert property (sleep_o && sclk_i |=> sleep_o)
        else $error("sleep left while serial clock high");
    wake_up_a: assert property (sleep_o && !sclk_i |-> ##[1:3] !sleep_o)
        else $error("no wake after serial clock low");
    read_stable_a: assert property (
        sclk_i && $past(sclk_i) && $past(sclk_i, 2) && !sleep_o |-> $stable(dout_o))
        else $error("data changed while serial clock high");
    tick_pulse_a: assert property (sample_tick_o |=> !sample_tick_o [*8])
        else $error("sample ticks too close");
    ext_osc_a: assert property ($changed(ext_clock_i) [*8] |-> ##[0:100] !osc_enable_o)
        else $error("oscillator not stopped by external clock");
endmodule
bind adc_conversion_and_readout_ctrl adc_ctrl_asserts adc_ctrl_asserts_inst (
    .clock_i(clock_i), .reset_i(reset_i), .digital_supply_ok_i(digital_supply_ok_i),
    .analog_supply_ok_i(analog_supply_ok_i), .ext_clock_i(ext_clock_i), .sclk_i(sclk_i),
    .dout_o(dout_o), .osc_enable_o(osc_enable_o), .sample_tick_o(sample_tick_o),
    .cal_active_o(cal_active_o), .sleep_o(sleep_o));
`default_nettype wire

// *** bench/host_model.sv ***
// Host model that clocks the two-wire readout from the far side.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic clock_i,
    input  wire logic dout_i,
    output logic      sclk_o
);
    initial sclk_o = 1'b0;
    task automatic set(input logic lvl);
        @(negedge clock_i);
        sclk_o = lvl;
    endtask
    // Four system clocks a phase keeps the serial clock at its 5 MHz ceiling.
    task automatic read(input int n, output logic [15:0] word);
        word = 16'h0000;
        for (int i = 1; i <= n; i++) begin
            set(1'b1);
            repeat (3) @(negedge clock_i);
            if (i <= 16) word = {word[14:0], dout_i};
            set(1'b0);
            repeat (3) @(negedge clock_i);
        end
    endtask
endmodule
`default_nettype wire

// *** bench/adc_conversion_and_readout_ctrl_test.sv ***
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_and_readout_ctrl_test;
    import adc_ctrl_pkg::*;
    localparam int CAL_SIM = 200;
    // A short decimation keeps three settling results well inside the run.
    localparam int DEC_SIM = 6;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        dig_ok  = 1'b1;
    logic        ana_ok  = 1'b1;
    logic        ext_clk = 1'b0;
    logic        ext_run = 1'b1;
    logic        mod_bit = 1'b1;
    logic        sclk, dout, osc_en, tick, cal_act, asleep;
    logic [15:0] w;
    int          ticks = 0;
    int          miscompares = 0;
    int          n_tests = 0;
    always #12.5 clock_i = ~clock_i;
    // A fast external clock keeps each modulator sample period short.
    always @(negedge clock_i) if (ext_run) ext_clk <= ~ext_clk;
    always @(posedge clock_i) if (tick === 1'b1) ticks <= ticks + 1;
    adc_conversion_and_readout_ctrl #(.GRADE_B(1'b0), .CAL_CYCLES(CAL_SIM), .DEC_LOG2(DEC_SIM))
    adc_conversion_and_readout_ctrl_inst (
        .clock_i(clock_i), .reset_i(reset_i), .digital_supply_ok_i(dig_ok),
        .analog_supply_ok_i(ana_ok), .ext_clock_i(ext_clk), .modulator_bit_i(mod_bit),
        .sclk_i(sclk), .dout_o(dout), .osc_enable_o(osc_en), .sample_tick_o(tick),
        .cal_active_o(cal_act), .sleep_o(asleep));
    host_model host_model_inst (.clock_i(clock_i), .dout_i(dout), .sclk_o(sclk));
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (dout !== 1'b0 && n < 8000) begin
            @(negedge clock_i);
            n++;
        end
        check("ready low", 16'h0000, {15'h0000, dout});
    endtask
    task automatic wait_cal_end();
        int n;
        n = 0;
        while (cal_act !== 1'b0 && n < CAL_SIM + 50) begin
            @(negedge clock_i);
            n++;
        end
        check("calibration ends", 16'h0000, {15'h0000, cal_act});
    endtask
    task automatic t_reset();
        reset_i = 1'b1;
        wait_n(5);
        check("dout in reset", 16'h0001, {15'h0000, dout});
        check("osc in reset", 16'h0001, {15'h0000, osc_en});
        reset_i = 1'b0;
        wait_n(4);
        check("cal after reset", 16'h0001, {15'h0000, cal_act});
        wait_cal_end();
        $display("t_reset done");
    endtask
    task automatic t_ext();
        int t0;
        t0 = ticks;
        wait_n(200);
        check("osc off by ext", 16'h0000, {15'h0000, osc_en});
        check("ticks run", 16'h0001, {15'h0000, ticks > t0});
        ext_run = 1'b0;
        wait_n(150);
        check("osc back on", 16'h0001, {15'h0000, osc_en});
        ext_run = 1'b1;
        $display("t_ext done");
    endtask
    task automatic t_read_pos();
        wait_ready();
        host_model_inst.read(25, w);
        check("word full scale", CODE_MAX, w);
        wait_n(2);
        check("idle after 25", 16'h0001, {15'h0000, dout});
        $display("t_read_pos done");
    endtask
    // The calibration clears the filter, so the first result holds only negative input.
    task automatic t_recal();
        mod_bit = 1'b0;
        wait_ready();
        host_model_inst.read(26, w);
        check("cal on 26th", 16'h0001, {15'h0000, cal_act});
        wait_cal_end();
        wait_ready();
        host_model_inst.read(25, w);
        check("word after cal", CODE_MIN, w);
        $display("t_recal done");
    endtask
    task automatic t_sleep();
        wait_ready();
        host_model_inst.set(1'b1);
        wait_n(SLEEP_CYCLES + 20);
        check("sleep entered", 16'h0001, {15'h0000, asleep});
        check("dout in sleep", 16'h0001, {15'h0000, dout});
        host_model_inst.set(1'b0);
        wait_n(4);
        check("awake", 16'h0000, {15'h0000, asleep});
        check("no stale ready", 16'h0001, {15'h0000, dout});
        $display("t_sleep done");
    endtask
    // Holding the 26th clock high sleeps; the wake-up then calibrates first.
    task automatic t_sleep_cal();
        wait_ready();
        host_model_inst.read(25, w);
        check("word after wake", CODE_MIN, w);
        host_model_inst.set(1'b1);
        wait_n(SLEEP_CYCLES + 20);
        check("sleep on 26th", 16'h0001, {15'h0000, asleep});
        host_model_inst.set(1'b0);
        wait_n(4);
        check("cal at wake", 16'h0001, {15'h0000, cal_act});
        wait_cal_end();
        $display("t_sleep_cal done");
    endtask
    task automatic t_supply();
        dig_ok = 1'b0;
        wait_n(5);
        check("digital low dout", 16'h0001, {15'h0000, dout});
        dig_ok = 1'b1;
        wait_n(4);
        check("cal after digital", 16'h0001, {15'h0000, cal_act});
        wait_cal_end();
        ana_ok = 1'b0;
        wait_n(5);
        check("analog low dout", 16'h0001, {15'h0000, dout});
        ana_ok = 1'b1;
        wait_n(4);
        check("no cal on analog", 16'h0000, {15'h0000, cal_act});
        $display("t_supply done");
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        t_reset();
        t_ext();
        t_read_pos();
        t_recal();
        t_sleep();
        t_sleep_cal();
        t_supply();
        results();
    end
    // About twice the cycles that the scenarios need together.
    initial begin
        wait_n(60000);
        miscompares++;
        results();
    end
endmodule
`default_nettype wire
